// file: common/ccu_map.svh
// Register offsets, field positions, reset values and timing counts of the
// capture/compare unit. Definitions only; included by bare name.
`ifndef CCU_MAP_SVH
`define CCU_MAP_SVH

`define CCU_WORD0 8'h00
`define CCU_TCNT0 8'h20
`define CCU_TREL0 8'h24
`define CCU_TCTL 8'h28
`define CCU_CFG0 8'h30
`define CCU_DBL 8'h38
`define CCU_REQ_LO 8'h3a
`define CCU_REQ_HI 8'h3b
`define CCU_TREQ 8'h3c
`define CCU_EN_LO 8'h3d
`define CCU_EN_HI 8'h3e
`define CCU_TEN 8'h3f

`define CCU_TCTL_SEL_W 3
`define CCU_TCTL_RUN 3
`define CCU_TCTL_STRIDE 4

`define CCU_RST_WORD 16'h0000
`define CCU_RST_CTL 16'h0000

`define CCU_RES_TCL 16
`define CCU_TCL_PS 5000
`define CCU_CLK_PS 10000
`define CCU_BASE_DIV ((`CCU_RES_TCL * `CCU_TCL_PS + `CCU_CLK_PS - 1) / `CCU_CLK_PS)

`endif

// file: common/ccu_pkg.sv
// Types shared by the capture/compare unit and its test environment.
// Assumes the offsets and counts come from ccu_map.svh.
`default_nettype none
package ccu_pkg;
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    CAP_RISE = 3'b001,
    CAP_FALL = 3'b010,
    CAP_BOTH = 3'b011,
    CMP_INT = 3'b100,
    CMP_TOGGLE = 3'b101,
    CMP_INT_ONCE = 3'b110,
    CMP_SET_ONCE = 3'b111
  } ccu_mode_t;

  typedef enum logic [2:0] {
    PRE_8 = 3'b000,
    PRE_16 = 3'b001,
    PRE_32 = 3'b010,
    PRE_64 = 3'b011,
    PRE_128 = 3'b100,
    PRE_256 = 3'b101,
    SEL_GP = 3'b110,
    SEL_EXT = 3'b111
  } ccu_clk_sel_t;

  typedef struct packed {
    logic alloc;
    ccu_mode_t mode;
  } chan_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ccu_bus_t;

  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe_n;
  } ccu_pins_t;

  typedef struct packed {
    logic [31:0] chan;
    logic [3:0] timer;
  } ccu_irq_t;
endpackage
`default_nettype wire

// file: src/ccu_word_bank.sv
// Thirty-two 16-bit capture/compare words with a registered read port.
// Assumes one bus write at a time; captures may hit any words at once.
`timescale 1ns/10ps
`default_nettype none
`include "ccu_map.svh"
module ccu_word_bank (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  input wire logic [4:0] rd_idx,
  input wire logic [31:0] cap_en,
  input wire logic [31:0][15:0] cap_val,
  output logic [15:0] rd_data,
  output logic [31:0][15:0] words
);
  logic [31:0][15:0] next_words;
  logic [15:0] next_rd;

  always_comb
  begin
    next_words = words;
    if (wr_en)
      next_words[wr_idx] = wr_data;
    for (int i = 0; i < 32; i++)
      if (cap_en[i])
        next_words[i] = cap_val[i];
    next_rd = rd_en ? words[rd_idx] : 16'h0000;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      words <= {32{`CCU_RST_WORD}};
      rd_data <= 16'h0000;
    end
    else if (clk_en)
    begin
      words <= next_words;
      rd_data <= next_rd;
    end
  end
endmodule
`default_nettype wire

// file: src/capture_compare_unit.sv
// Capture/compare unit: four 16-bit timers in two pairs, two arrays of
// sixteen channels. Assumes pins and strobes synchronous to core_clk.
//
// Overview of operation
// - Thirty-two channels, finest step sixteen timing units
// - Four reloadable timers, two pairs, two time bases
// - Timer clock: prescaled clock or gp overflow
// - First timer of pair counts external events
// - Sixteen channels per array, own timer, mode
// - Each channel one pin; 24-27 input only
// - Capture copies allocated timer on pin event
// - Every capture raises its channel request
// - Capture edge: rising, falling or both
// - Compare modes match timer, then act
// - Each source own request, enable, interrupt line
// - Mode 0 many, mode 2 one interrupt
// - Mode 1 toggles pin on every match
// - Mode 3 sets on match, clears on overflow
// - Paired registers toggle one shared pin
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ccu_map.svh"
module capture_compare_unit (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire ccu_pkg::ccu_bus_t bus,
  output logic [15:0] rd_data,
  input wire logic [31:0] pin_in,
  input wire logic [1:0] ext_count,
  input wire logic gp_ovf,
  output ccu_pkg::ccu_pins_t pins,
  output ccu_pkg::ccu_irq_t irq
);
  import ccu_pkg::*;

  logic [3:0][15:0] tcnt, next_tcnt, trel, next_trel;
  logic [15:0] tctl, next_tctl;
  logic [7:0] pre, next_pre;
  logic [3:0] step, next_step, ovf, next_ovf, tick;
  logic [1:0] ext_prev;
  chan_cfg_t [31:0] cfg, next_cfg;
  logic [15:0] dbl, next_dbl;
  logic [31:0] pin_out, next_pin_out, done, next_done, pin_prev;
  logic [31:0] req, next_req, en, next_en;
  logic [3:0] treq, next_treq, ten, next_ten;
  logic [15:0] rd_q, next_rd_q, bank_rd;
  logic [31:0][15:0] words, cap_val;
  logic [31:0] cap_ev, hit, toggle, drive;

  function automatic logic prescale_tick(input logic [2:0] sel, input logic [7:0] cnt);
    logic [8:0] mask;
    mask = 9'(9'(`CCU_BASE_DIV) << sel) - 9'h001;
    return &(cnt | ~mask[7:0]);
  endfunction

  function automatic logic [1:0] timer_of(input int ch, input logic alloc);
    return {(ch >= 16), alloc};
  endfunction

  // Timers and prescaler
  always_comb
  begin
    next_tcnt = tcnt;
    next_trel = trel;
    next_tctl = tctl;
    next_pre = pre + 8'h01;
    next_step = 4'h0;
    next_ovf = 4'h0;
    for (int t = 0; t < 4; t++)
    begin
      if (tctl[4 * t +: 3] == SEL_GP)
        tick[t] = gp_ovf;
      else if (tctl[4 * t +: 3] == SEL_EXT)
        tick[t] = (t % 2 == 0) && ext_count[t / 2] && !ext_prev[t / 2];
      else
        tick[t] = prescale_tick(tctl[4 * t +: 3], pre);
      tick[t] = tick[t] && tctl[`CCU_TCTL_STRIDE * t + `CCU_TCTL_RUN] && clk_en;
      if (tick[t])
      begin
        next_step[t] = 1'b1;
        if (tcnt[t] == 16'hffff)
        begin
          next_tcnt[t] = trel[t];
          next_ovf[t] = 1'b1;
        end
        else
          next_tcnt[t] = tcnt[t] + 16'h0001;
      end
      // A software count write overrides a tick: no step, no overflow
      if (bus.wr && bus.addr == 8'(`CCU_TCNT0 + t))
      begin
        next_tcnt[t] = bus.wdata;
        next_step[t] = 1'b0;
        next_ovf[t] = 1'b0;
      end
      if (bus.wr && bus.addr == 8'(`CCU_TREL0 + t))
        next_trel[t] = bus.wdata;
    end
    if (bus.wr && bus.addr == `CCU_TCTL)
      next_tctl = bus.wdata;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tcnt <= '0;
      trel <= '0;
      tctl <= `CCU_RST_CTL;
      pre <= 8'h00;
      step <= 4'h0;
      ovf <= 4'h0;
      ext_prev <= 2'h0;
    end
    else if (clk_en)
    begin
      tcnt <= next_tcnt;
      trel <= next_trel;
      tctl <= next_tctl;
      pre <= next_pre;
      step <= next_step;
      ovf <= next_ovf;
      ext_prev <= ext_count;
    end
  end

  // Channel events: timer steps are seen in the same cycle as the new count
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      cap_val[i] = tcnt[timer_of(i, cfg[i].alloc)];
      cap_ev[i] = !cfg[i].mode[2]
        && ((cfg[i].mode[0] && pin_in[i] && !pin_prev[i])
        || (cfg[i].mode[1] && !pin_in[i] && pin_prev[i]));
      hit[i] = cfg[i].mode[2] && step[timer_of(i, cfg[i].alloc)]
        && words[i] == cap_val[i] && !(cfg[i].mode[1] && done[i]);
      toggle[i] = hit[i] && cfg[i].mode == CMP_TOGGLE;
      drive[i] = (cfg[i].mode == CMP_TOGGLE || cfg[i].mode == CMP_SET_ONCE)
        && !(i >= 24 && i <= 27);
    end
    for (int p = 0; p < 16; p++)
    begin
      if (dbl[p] && cfg[(p / 8) * 16 + p % 8 + 8].mode == CMP_TOGGLE
          && cfg[(p / 8) * 16 + p % 8].mode == CMP_TOGGLE)
      begin
        toggle[(p / 8) * 16 + p % 8] = toggle[(p / 8) * 16 + p % 8]
          || toggle[(p / 8) * 16 + p % 8 + 8];
        toggle[(p / 8) * 16 + p % 8 + 8] = 1'b0;
        drive[(p / 8) * 16 + p % 8 + 8] = 1'b0;
      end
    end
  end

  // Channel configuration and pin state
  always_comb
  begin
    next_cfg = cfg;
    next_dbl = dbl;
    next_done = done;
    next_pin_out = pin_out;
    for (int i = 0; i < 32; i++)
    begin
      next_done[i] = (done[i] && !ovf[timer_of(i, cfg[i].alloc)])
        || (hit[i] && cfg[i].mode[1]);
      if (cfg[i].mode == CMP_SET_ONCE)
      begin
        if (hit[i])
          next_pin_out[i] = 1'b1;
        else if (ovf[timer_of(i, cfg[i].alloc)])
          next_pin_out[i] = 1'b0;
      end
      else if (toggle[i])
        next_pin_out[i] = !pin_out[i];
    end
    for (int r = 0; r < 8; r++)
      if (bus.wr && bus.addr == 8'(`CCU_CFG0 + r))
        next_cfg[4 * r +: 4] = bus.wdata;
    if (bus.wr && bus.addr == `CCU_DBL)
      next_dbl = bus.wdata;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg <= '0;
      dbl <= 16'h0000;
      done <= 32'h0000_0000;
      pin_out <= 32'h0000_0000;
      pin_prev <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      cfg <= next_cfg;
      dbl <= next_dbl;
      done <= next_done;
      pin_out <= next_pin_out;
      pin_prev <= pin_in;
    end
  end

  // Request and enable flags; a hardware set wins over a software clear
  always_comb
  begin
    next_req = req;
    next_en = en;
    next_treq = treq;
    next_ten = ten;
    if (bus.wr)
    begin
      case (bus.addr)
        `CCU_REQ_LO: next_req[15:0] = bus.wdata;
        `CCU_REQ_HI: next_req[31:16] = bus.wdata;
        `CCU_TREQ: next_treq = bus.wdata[3:0];
        `CCU_EN_LO: next_en[15:0] = bus.wdata;
        `CCU_EN_HI: next_en[31:16] = bus.wdata;
        `CCU_TEN: next_ten = bus.wdata[3:0];
        default: ;
      endcase
    end
    next_req = next_req | cap_ev | hit;
    next_treq = next_treq | ovf;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req <= 32'h0000_0000;
      en <= 32'h0000_0000;
      treq <= 4'h0;
      ten <= 4'h0;
    end
    else if (clk_en)
    begin
      req <= next_req;
      en <= next_en;
      treq <= next_treq;
      ten <= next_ten;
    end
  end

  // Read data for everything outside the word bank; zero when not read
  always_comb
  begin
    next_rd_q = 16'h0000;
    if (bus.rd)
    begin
      if (bus.addr[7:3] == 5'h04)
        next_rd_q = bus.addr[2] ? trel[bus.addr[1:0]] : tcnt[bus.addr[1:0]];
      for (int r = 0; r < 8; r++)
        if (bus.addr == 8'(`CCU_CFG0 + r))
          next_rd_q = cfg[4 * r +: 4];
      case (bus.addr)
        `CCU_TCTL: next_rd_q = tctl;
        `CCU_DBL: next_rd_q = dbl;
        `CCU_REQ_LO: next_rd_q = req[15:0];
        `CCU_REQ_HI: next_rd_q = req[31:16];
        `CCU_TREQ: next_rd_q = {12'h000, treq};
        `CCU_EN_LO: next_rd_q = en[15:0];
        `CCU_EN_HI: next_rd_q = en[31:16];
        `CCU_TEN: next_rd_q = {12'h000, ten};
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_q <= 16'h0000;
    else if (clk_en)
      rd_q <= next_rd_q;
  end

  ccu_word_bank u_bank (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .wr_en(bus.wr && bus.addr < 8'h20),
    .wr_idx(bus.addr[4:0]),
    .wr_data(bus.wdata),
    .rd_en(bus.rd && bus.addr < 8'h20),
    .rd_idx(bus.addr[4:0]),
    .cap_en(cap_ev),
    .cap_val(cap_val),
    .rd_data(bank_rd),
    .words(words)
  );

  assign rd_data = bank_rd | rd_q;
  assign pins.out = pin_out;
  assign pins.oe_n = ~drive;
  assign irq.chan = req & en;
  assign irq.timer = treq & ten;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_capture_value_copy: assert property (
    clk_en && cap_ev[0] |=> words[0] == $past(cap_val[0]))
    else $error("capture did not copy the allocated timer");
  a_capture_sets_flag: assert property (
    clk_en && cap_ev != 32'h0000_0000 |=> (req & $past(cap_ev)) == $past(cap_ev))
    else $error("capture event left its request flag clear");
  a_flag_stays_set: assert property (
    req[0] && !(bus.wr && bus.addr == `CCU_REQ_LO) |=> req[0])
    else $error("request flag dropped without a clear");
  a_match_reaches_irq: assert property (
    clk_en && hit[0] && en[0] |=> irq.chan[0])
    else $error("enabled compare match gave no interrupt");
  a_wrap_reloads: assert property (
    tick[0] && tcnt[0] == 16'hffff && !(bus.wr && bus.addr == `CCU_TCNT0)
    |=> tcnt[0] == $past(trel[0]) && ovf[0])
    else $error("timer overflow did not reload");
  a_wrap_flag: assert property (
    clk_en && ovf[0] |=> treq[0])
    else $error("timer overflow did not raise its request");
  a_toggle_on_match: assert property (
    clk_en && toggle[0] |=> pins.out[0] != $past(pins.out[0]))
    else $error("toggle mode pin did not change");
  a_set_once_pin: assert property (
    clk_en && hit[0] && cfg[0].mode == CMP_SET_ONCE |=> pins.out[0] && done[0])
    else $error("set-once match did not raise the pin");
  a_once_per_period: assert property (
    clk_en && hit[0] && cfg[0].mode[1] && !ovf[cfg[0].alloc] |=> done[0] && !hit[0])
    else $error("second match in one period");
  a_input_only_pins: assert property (
    pins.oe_n[27:24] == 4'hf)
    else $error("input-only channel drives its pin");
  a_prescale_gap: assert property (
    tick[0] && tctl[2:0] == PRE_8 |=> !tick[0] [*7])
    else $error("timer stepped faster than the finest resolution");

  c_capture: cover property (clk_en && cap_ev[0]);
  c_wrap: cover property (clk_en && ovf[0] && treq[0]);
  c_double_pair: cover property (clk_en && dbl[0] && hit[8] && toggle[0]);
  c_set_once: cover property (clk_en && hit[1] && cfg[1].mode == CMP_SET_ONCE);
endmodule
`default_nettype wire

// file: bench/ccu_far_side.sv
// Far side of the capture/compare unit: port pins and count sources.
// Assumes the bench asks for pin levels and count pulses on core_clk edges.
`timescale 1ns/10ps
`default_nettype none
module ccu_far_side
  import ccu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] drive,
  input wire logic gp_req,
  input wire logic [1:0] ext_req,
  input wire ccu_pkg::ccu_pins_t pins,
  output logic [31:0] pin_in,
  output logic gp_ovf,
  output logic [1:0] ext_count
);
  // Pin level: the unit wins where it drives, the outside world elsewhere
  always_comb
  begin
    for (int i = 0; i < 32; i++)
      pin_in[i] = pins.oe_n[i] ? drive[i] : pins.out[i];
  end

  // Overflow of the gp timer is a one-cycle pulse
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      gp_ovf <= 1'b0;
    else
      gp_ovf <= gp_req;
  end

  assign ext_count = ext_req;
endmodule
`default_nettype wire

// file: bench/capture_compare_unit_test.sv
// Self-checking bench for the capture/compare unit.
// Assumes ccu_far_side stands at the pins; registers reached over the bus.
`timescale 1ns/10ps
`default_nettype none
module capture_compare_unit_test;
  import ccu_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  ccu_bus_t bus = '0;
  logic [15:0] rd_data;
  logic [31:0] pin_in;
  logic [1:0] ext_count;
  logic gp_ovf;
  ccu_pins_t pins;
  ccu_irq_t irq;
  logic [31:0] drive = '0;
  logic gp_req = 1'b0;
  logic [1:0] ext_req = '0;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [15:0] v;

  always #5 core_clk = ~core_clk;

  capture_compare_unit i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .bus(bus), .rd_data(rd_data), .pin_in(pin_in), .ext_count(ext_count),
    .gp_ovf(gp_ovf), .pins(pins), .irq(irq));

  ccu_far_side i_far (.core_clk(core_clk), .rst_n(rst_n), .drive(drive),
    .gp_req(gp_req), .ext_req(ext_req), .pins(pins), .pin_in(pin_in),
    .gp_ovf(gp_ovf), .ext_count(ext_count));

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge core_clk);
    bus <= '0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    bus <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge core_clk);
    bus <= '0;
    #1;
    d = rd_data;
  endtask

  task automatic gp_pulse();
    @(posedge core_clk);
    gp_req <= 1'b1;
    @(posedge core_clk);
    gp_req <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  task automatic ext_pulse();
    @(posedge core_clk);
    ext_req <= 2'b01;
    @(posedge core_clk);
    ext_req <= 2'b00;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic set_drive(input logic [31:0] d);
    @(posedge core_clk);
    drive <= d;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic test_reset();
    chk_vec(pins.oe_n, 32'hffff_ffff);
    chk_vec(irq.chan, 32'h0000_0000);
    rd(8'h30, v);
    chk_word(v, 16'h0000);
    rd(8'h40, v);
    chk_word(v, 16'h0000);
    $display("test reset done");
  endtask

  // Timer a1 counts gp overflows, wraps to reload, request masked then enabled
  task automatic test_timer();
    wr(8'h24, 16'h1234);
    wr(8'h20, 16'hfffe);
    wr(8'h28, 16'h000e);
    gp_pulse();
    rd(8'h20, v);
    chk_word(v, 16'hffff);
    gp_pulse();
    rd(8'h20, v);
    chk_word(v, 16'h1234);
    rd(8'h3c, v);
    chk_word(v, 16'h0001);
    chk_vec({28'h0, irq.timer}, 32'h0000_0000);
    wr(8'h3f, 16'h0001);
    chk_vec({28'h0, irq.timer}, 32'h0000_0001);
    wr(8'h3c, 16'h0000);
    chk_vec({28'h0, irq.timer}, 32'h0000_0000);
    $display("test timer done");
  endtask

  // ch0 rising, ch1 falling, ch2 both edges
  task automatic test_capture();
    wr(8'h30, 16'h0321);
    set_drive(32'h0000_0007);
    wr(8'h20, 16'h5678);
    set_drive(32'h0000_0000);
    rd(8'h00, v);
    chk_word(v, 16'h1234);
    rd(8'h01, v);
    chk_word(v, 16'h5678);
    rd(8'h02, v);
    chk_word(v, 16'h5678);
    rd(8'h3a, v);
    chk_word(v, 16'h0007);
    wr(8'h3d, 16'h0004);
    chk_vec(irq.chan, 32'h0000_0004);
    $display("test capture done");
  endtask

  // ch4 toggles on match; ch24 never drives; external count steps a1
  task automatic test_compare();
    wr(8'h04, 16'h5679);
    wr(8'h31, 16'h0005);
    chk_vec({31'h0, pins.oe_n[4]}, 32'h0000_0000);
    chk_vec({31'h0, pins.out[4]}, 32'h0000_0000);
    gp_pulse();
    chk_vec({31'h0, pins.out[4]}, 32'h0000_0001);
    rd(8'h3a, v);
    chk_word(v, 16'h0017);
    wr(8'h36, 16'h0005);
    chk_vec({31'h0, pins.oe_n[24]}, 32'h0000_0001);
    wr(8'h28, 16'h000f);
    ext_pulse();
    rd(8'h20, v);
    chk_word(v, 16'h567a);
    chk_vec({31'h0, pins.out[4]}, 32'h0000_0001);
    $display("test compare done");
  endtask

  // Frozen clock enable; ch1/ch9 double pair; ch8 set-once cleared by wrap
  task automatic test_modes();
    @(posedge core_clk);
    clk_en <= 1'b0;
    ext_pulse();
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(8'h20, v);
    chk_word(v, 16'h567a);
    wr(8'h01, 16'h567c);
    wr(8'h08, 16'h567b);
    wr(8'h09, 16'h567b);
    wr(8'h30, 16'h0050);
    wr(8'h32, 16'h0057);
    wr(8'h38, 16'h0002);
    chk_vec(pins.oe_n & 32'h0000_0302, 32'h0000_0200);
    ext_pulse();
    chk_vec(pins.out & 32'h0000_0302, 32'h0000_0102);
    ext_pulse();
    chk_vec(pins.out & 32'h0000_0302, 32'h0000_0100);
    wr(8'h20, 16'hffff);
    ext_pulse();
    chk_vec(pins.out & 32'h0000_0100, 32'h0000_0000);
    rd(8'h3a, v);
    chk_word(v, 16'h0317);
    $display("test modes done");
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    test_reset();
    test_timer();
    test_capture();
    test_compare();
    test_modes();
    finish_test();
  end

  initial
  begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire
